/* File: rtl/sfc_pkg.sv */
/*
  Shared constants and types for the serial flash command front end.
  It assumes a 200 MHz system clock and an SPI clock far slower than it.
*/
// Functional notes
// R1: After power-up or reset the serial output stays undriven until a read instruction drives it.
// R2: An instruction is taken only after a falling edge of select, which the host must produce.
// R3: Each select falling edge samples the idle clock level: high picks mode 3, low picks mode 0.
// R4: While power-on reset is active the block stays in reset and ignores every command.
// R5: The host must not select the part for a read until 70 us after the supply threshold.
// R6: A first program or erase must wait for the supply and a further delay of up to 3 ms.
// R7: After the power-up write delay the part is in standby with select high, active with it low.
// R8: Opcode D2h carries 4 ignored bits, an 11-bit page, a 9-bit byte address, then 4 dummy bytes.
// R9: D1h and D3h carry 15 ignored bits and a 9-bit byte address; D4h and D6h add one dummy byte.
// R10: Opcodes 9Fh, B9h, ABh, B0h, D0h and D7h are a lone opcode byte with no address or dummy.
package sfc_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MAIN_READ = 8'hd2;
  localparam logic [7:0] OP_BUF1_READ_LF = 8'hd1;
  localparam logic [7:0] OP_BUF2_READ_LF = 8'hd3;
  localparam logic [7:0] OP_BUF1_READ = 8'hd4;
  localparam logic [7:0] OP_BUF2_READ = 8'hd6;
  localparam logic [7:0] OP_ID_READ = 8'h9f;
  localparam logic [7:0] OP_DEEP_DOWN = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_CONFIG = 8'hb0;
  localparam logic [7:0] OP_SUSPEND = 8'hd0;
  localparam logic [7:0] OP_STATUS = 8'hd7;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int PAGE_W = 11;
  localparam int BADDR_W = 9;
  localparam int PAGE_LSB = 9;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [2:0] DUMMY_MAIN = 3'h4;
  localparam logic [2:0] DUMMY_BUF = 3'h1;
  localparam logic [2:0] DUMMY_NONE = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PUW_MS = 3;
  localparam int unsigned VCSL_US = 70;
  localparam int unsigned PUW_CYC = PUW_MS * 1000 * CLK_MHZ;
  localparam int unsigned VCSL_CYC = VCSL_US * CLK_MHZ;
  localparam int CNT_W = 20;

  // ----------------------------------------------------------------
  // Reset values and states
  // ----------------------------------------------------------------
  localparam logic CS_IDLE = 1'b1;
  localparam logic POR_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ST_POR, ST_IDLE, ST_OPC, ST_LAYOUT, ST_ADDR, ST_DUMMY, ST_DATA, ST_HOLD
  } sfc_state_t;

endpackage

/* File: rtl/sfc_dec_if.sv */
/*
  Carrier between the frame engine and the opcode layout decoder.
  It assumes both ends share clk_sys.
*/
interface sfc_dec_if;
  logic [7:0] op;
  logic op_stb;
  logic known;
  logic has_addr;
  logic wide_page;
  logic is_read;
  logic [2:0] dummy;

  modport ctrl (output op, output op_stb,
    input known, input has_addr, input wide_page, input is_read, input dummy);
  modport dec (input op, input op_stb,
    output known, output has_addr, output wide_page, output is_read, output dummy);
endinterface

/* File: rtl/sfc_decode.sv */
/*
  Opcode layout decoder: registers address, dummy and direction per opcode.
  It assumes op_stb is a one-cycle pulse with op valid beside it.
*/
module sfc_decode (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Layout port
  sfc_dec_if.dec bus
);

  // ----------------------------------------------------------------
  // Layout table
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus.known <= 1'b0;
      bus.has_addr <= 1'b0;
      bus.wide_page <= 1'b0;
      bus.is_read <= 1'b0;
      bus.dummy <= sfc_pkg::DUMMY_NONE;
    end else if (bus.op_stb) begin
      bus.known <= 1'b1;
      bus.has_addr <= 1'b0;
      bus.wide_page <= 1'b0;
      bus.is_read <= 1'b0;
      bus.dummy <= sfc_pkg::DUMMY_NONE;
      case (bus.op)
        sfc_pkg::OP_MAIN_READ: begin // R8
          bus.has_addr <= 1'b1;
          bus.wide_page <= 1'b1;
          bus.is_read <= 1'b1;
          bus.dummy <= sfc_pkg::DUMMY_MAIN;
        end
        sfc_pkg::OP_BUF1_READ_LF, sfc_pkg::OP_BUF2_READ_LF: begin // R9
          bus.has_addr <= 1'b1;
          bus.is_read <= 1'b1;
        end
        sfc_pkg::OP_BUF1_READ, sfc_pkg::OP_BUF2_READ: begin // R9
          bus.has_addr <= 1'b1;
          bus.is_read <= 1'b1;
          bus.dummy <= sfc_pkg::DUMMY_BUF;
        end
        sfc_pkg::OP_ID_READ, sfc_pkg::OP_STATUS: begin // R10
          bus.is_read <= 1'b1;
        end
        sfc_pkg::OP_DEEP_DOWN, sfc_pkg::OP_WAKE, sfc_pkg::OP_CONFIG,
        sfc_pkg::OP_SUSPEND: begin // R10
          bus.is_read <= 1'b0;
        end
        default: begin
          bus.known <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_MAIN_LAYOUT: assert property (bus.op_stb && bus.op == sfc_pkg::OP_MAIN_READ |=> // R8
    bus.has_addr && bus.wide_page && bus.dummy == 3'h4 && bus.is_read)
    else $error("main page read layout wrong");
  AST_BUF_LAYOUT: assert property (bus.op_stb && (bus.op == 8'hd1 || bus.op == 8'hd3) |=> // R9
    bus.has_addr && !bus.wide_page && bus.dummy == 3'h0)
    else $error("buffer read layout wrong");
  AST_BUF_DUMMY: assert property (bus.op_stb && (bus.op == 8'hd4 || bus.op == 8'hd6) |=> // R9
    bus.has_addr && !bus.wide_page && bus.dummy == 3'h1)
    else $error("buffer read dummy count wrong");
  AST_NO_ADDR: assert property (bus.op_stb && (bus.op == 8'h9f || bus.op == 8'hb9 || // R10
    bus.op == 8'hab || bus.op == 8'hb0 || bus.op == 8'hd0 || bus.op == 8'hd7) |=>
    bus.known && !bus.has_addr && bus.dummy == 3'h0)
    else $error("single byte opcode given a header");

endmodule

/* File: rtl/sfc_top.sv */
/*
  Serial flash front end: pin synchronisers, power-up gating, frame parsing
  and read-data shifting. It assumes SCK is at least eight times slower than
  clk_sys and that rd_byte is ready whenever rd_req has not just pulsed.
*/
module sfc_top #(
  parameter int unsigned PUW_CYCLES = sfc_pkg::PUW_CYC,
  parameter int unsigned VCSL_CYCLES = sfc_pkg::VCSL_CYC
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Supply monitor
  input wire logic por_active,
  // SPI pins
  input wire logic sck,
  input wire logic select_low_pin,
  input wire logic si,
  output logic so_dat,
  output logic so_oe,
  // Core side
  input wire logic [7:0] rd_byte,
  output logic rd_req,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [sfc_pkg::PAGE_W-1:0] cmd_page,
  output logic [sfc_pkg::BADDR_W-1:0] cmd_byte,
  output logic mode3,
  output logic active,
  output logic standby,
  output logic pe_allowed,
  output logic read_allowed
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sck_s_r;
  logic [1:0] cs_s_r;
  logic [1:0] si_s_r;
  logic [1:0] por_s_r;
  logic sck_d_r;
  logic cs_d_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_s_r <= 2'h0;
      si_s_r <= 2'h0;
      cs_s_r <= {2{sfc_pkg::CS_IDLE}};
      por_s_r <= {2{sfc_pkg::POR_IDLE}};
      sck_d_r <= 1'b0;
      cs_d_r <= sfc_pkg::CS_IDLE;
    end else begin
      sck_s_r <= {sck_s_r[0], sck};
      si_s_r <= {si_s_r[0], si};
      cs_s_r <= {cs_s_r[0], select_low_pin};
      por_s_r <= {por_s_r[0], por_active};
      sck_d_r <= sck_s_r[1];
      cs_d_r <= cs_s_r[1];
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic por_on;
  assign sck_rise = sck_s_r[1] & ~sck_d_r;
  assign sck_fall = ~sck_s_r[1] & sck_d_r;
  assign cs_fall = ~cs_s_r[1] & cs_d_r;
  assign cs_rise = cs_s_r[1] & ~cs_d_r;
  assign por_on = por_s_r[1];

  // ----------------------------------------------------------------
  // Power-up delays
  // ----------------------------------------------------------------
  logic [sfc_pkg::CNT_W-1:0] pu_cnt_r;
  logic pu_done;
  assign pu_done = pu_cnt_r >= sfc_pkg::CNT_W'(PUW_CYCLES);

  always_ff @(posedge clk_sys) begin
    if (rst || por_on) begin
      pu_cnt_r <= '0;
    end else if (!pu_done) begin
      pu_cnt_r <= pu_cnt_r + sfc_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || por_on) begin
      pe_allowed <= 1'b0;
      read_allowed <= 1'b0;
      active <= 1'b0;
      standby <= 1'b0;
    end else begin
      pe_allowed <= pu_done;
      read_allowed <= pu_cnt_r >= sfc_pkg::CNT_W'(VCSL_CYCLES);
      active <= pu_done & ~cs_s_r[1]; // R7
      standby <= pu_done & cs_s_r[1]; // R7
    end
  end

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  sfc_dec_if dec_if ();
  sfc_decode u_decode (
    .clk_sys (clk_sys),
    .rst (rst),
    .bus (dec_if)
  );

  sfc_pkg::sfc_state_t state_r;
  sfc_pkg::sfc_state_t state_nxt;
  logic [7:0] in_sh_r;
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [sfc_pkg::ADDR_W-1:0] addr_r;
  logic byte_done;
  logic hdr_end;
  assign byte_done = sck_rise && bit_cnt_r == 3'h7;
  logic [sfc_pkg::ADDR_W-1:0] addr_full;
  assign addr_full = (state_r == sfc_pkg::ST_ADDR) ?
    {addr_r[sfc_pkg::ADDR_W-2:0], si_s_r[1]} : addr_r;

  always_comb begin
    state_nxt = state_r;
    hdr_end = 1'b0;
    unique case (state_r)
      sfc_pkg::ST_POR: state_nxt = sfc_pkg::ST_IDLE;
      sfc_pkg::ST_IDLE: if (cs_fall) state_nxt = sfc_pkg::ST_OPC; // R2
      sfc_pkg::ST_OPC: if (byte_done) state_nxt = sfc_pkg::ST_LAYOUT;
      sfc_pkg::ST_LAYOUT: begin
        // The decoder answers one cycle after its strobe, so the choice waits for it.
        if (dec_if.op_stb) begin
          state_nxt = sfc_pkg::ST_LAYOUT;
        end else if (!dec_if.known) begin
          state_nxt = sfc_pkg::ST_HOLD;
        end else if (dec_if.has_addr) begin
          state_nxt = sfc_pkg::ST_ADDR;
        end else begin
          hdr_end = 1'b1; // R10
          state_nxt = sfc_pkg::ST_DATA;
        end
      end
      sfc_pkg::ST_ADDR: begin
        if (byte_done && byte_cnt_r == {1'b0, sfc_pkg::ADDR_BYTES} - 3'h1) begin
          if (dec_if.dummy == sfc_pkg::DUMMY_NONE) begin
            hdr_end = 1'b1; // R9
            state_nxt = sfc_pkg::ST_DATA;
          end else begin
            state_nxt = sfc_pkg::ST_DUMMY;
          end
        end
      end
      sfc_pkg::ST_DUMMY: begin
        if (byte_done && byte_cnt_r == dec_if.dummy - 3'h1) begin
          hdr_end = 1'b1; // R8
          state_nxt = sfc_pkg::ST_DATA;
        end
      end
      sfc_pkg::ST_DATA: state_nxt = sfc_pkg::ST_DATA;
      sfc_pkg::ST_HOLD: state_nxt = sfc_pkg::ST_HOLD;
    endcase
    if (cs_rise && state_r != sfc_pkg::ST_POR) state_nxt = sfc_pkg::ST_IDLE;
    if (por_on) begin
      state_nxt = sfc_pkg::ST_POR; // R4
      hdr_end = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= sfc_pkg::ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Mode only decides whether the first clock edge is a falling one, which
  // the shifter ignores anyway, so it is reported rather than steering logic.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode3 <= 1'b0;
    end else if (state_r != sfc_pkg::ST_POR && cs_fall) begin
      mode3 <= sck_s_r[1]; // R3
    end
  end

  // ----------------------------------------------------------------
  // Header shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || state_r == sfc_pkg::ST_IDLE) begin
      in_sh_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      addr_r <= '0;
    end else begin
      if (state_r == sfc_pkg::ST_LAYOUT) byte_cnt_r <= 3'h0;
      if (sck_rise) begin
        in_sh_r <= {in_sh_r[6:0], si_s_r[1]};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (state_r == sfc_pkg::ST_ADDR) addr_r <= {addr_r[sfc_pkg::ADDR_W-2:0], si_s_r[1]};
      end
      if (byte_done && state_r == sfc_pkg::ST_ADDR && state_nxt == sfc_pkg::ST_DUMMY) begin
        byte_cnt_r <= 3'h0;
      end else if (byte_done) begin
        byte_cnt_r <= byte_cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dec_if.op <= 8'h00;
      dec_if.op_stb <= 1'b0;
    end else begin
      dec_if.op_stb <= state_r == sfc_pkg::ST_OPC && byte_done && !por_on;
      if (state_r == sfc_pkg::ST_OPC && byte_done) dec_if.op <= {in_sh_r[6:0], si_s_r[1]};
    end
  end

  // ----------------------------------------------------------------
  // Command report
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_page <= '0;
      cmd_byte <= '0;
    end else begin
      cmd_valid <= hdr_end;
      if (hdr_end) begin
        cmd_opcode <= dec_if.op;
        cmd_page <= dec_if.wide_page ?
          addr_full[sfc_pkg::PAGE_LSB +: sfc_pkg::PAGE_W] : '0; // R8
        cmd_byte <= addr_full[sfc_pkg::BADDR_W-1:0]; // R9
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data output
  // ----------------------------------------------------------------
  logic [7:0] out_sh_r;
  logic [2:0] out_cnt_r;

  always_ff @(posedge clk_sys) begin
    if (rst || por_on || cs_rise) begin
      so_oe <= 1'b0; // R1
      so_dat <= 1'b0;
      out_sh_r <= 8'h00;
      out_cnt_r <= 3'h0;
      rd_req <= 1'b0;
    end else begin
      rd_req <= 1'b0;
      if (hdr_end && dec_if.is_read) begin
        so_oe <= 1'b1; // R1
        out_sh_r <= rd_byte;
        out_cnt_r <= 3'h0;
        rd_req <= 1'b1;
      end else if (so_oe && sck_fall) begin
        so_dat <= out_sh_r[7];
        out_cnt_r <= out_cnt_r + 3'h1;
        if (out_cnt_r == 3'h7) begin
          out_sh_r <= rd_byte;
          rd_req <= 1'b1;
        end else begin
          out_sh_r <= {out_sh_r[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_idle_fall;
    state_r == sfc_pkg::ST_IDLE && cs_fall && !por_on;
  endsequence

  AST_POR_HIZ: assert property (por_on |=> !so_oe && !cmd_valid) // R4
    else $error("output driven or command taken during power-on reset");
  AST_OE_READ_ONLY: assert property ($rose(so_oe) |-> $past(hdr_end && dec_if.is_read)) // R1
    else $error("output enabled without a read header");
  AST_CMD_AFTER_FALL: assert property (cmd_valid |-> $past(state_r) != sfc_pkg::ST_IDLE) // R2
    else $error("command reported without a select falling edge");
  AST_MODE_SAMPLE: assert property (s_idle_fall |=> mode3 == $past(sck_s_r[1])) // R3
    else $error("spi mode not taken from idle clock level");
  AST_STANDBY: assert property (pu_done && cs_s_r[1] && !por_on |=> standby && !active) // R7
    else $error("standby not shown with select high");
  AST_ACTIVE: assert property (pu_done && !cs_s_r[1] && !por_on |=> active && !standby) // R7
    else $error("active not shown with select low");
  AST_OE_DROP: assert property (cs_rise |=> !so_oe [*2]) // R1
    else $error("output still driven after deselect");
  AST_D2_PAGE: assert property (hdr_end && dec_if.op == 8'hd2 |=> // R8
    cmd_valid && cmd_page == $past(addr_r[19:9]) && cmd_byte == $past(addr_r[8:0]))
    else $error("page read fields misdecoded");

endmodule

/* File: sim/sfc_host_model.sv */
/*
  SPI host model that frames commands and clocks reply bytes back in.
  It assumes a 200 MHz clk_sys; every pin change lands on its falling edge.
*/
module sfc_host_model #(
  parameter int HALF = 16
) (
  // System
  input wire logic clk_sys,
  // SPI pins
  output logic sck,
  output logic select_low_pin,
  output logic si,
  input wire logic so_dat,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck = 1'b0;
    select_low_pin = 1'b1;
    si = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic set_sel(input logic v);
    select_low_pin = v;
  endtask

  // A released output reads as z, so an undriven pin never matches a data byte.
  task automatic bit_io(input logic b, output logic q);
    sck = 1'b0;
    si = b;
    tick(HALF);
    sck = 1'b1;
    q = so_oe ? so_dat : 1'bz;
    tick(HALF);
  endtask

  // The clock stands at its idle level outside frames; si toggles so no stale bit lingers.
  task automatic frame(input logic idle, input logic fall, input logic [7:0] op,
      input logic [23:0] addr, input int naddr, input int ndum, input int nrd,
      output logic [7:0] rdata);
    logic q;
    rdata = 8'h00;
    sck = idle;
    tick(4);
    if (fall) begin
      select_low_pin = 1'b1;
      tick(4);
    end
    select_low_pin = 1'b0;
    tick(6);
    for (int i = 7; i >= 0; i--) bit_io(op[i], q);
    for (int i = 23; i >= 24 - naddr; i--) bit_io(addr[i], q);
    for (int i = 0; i < ndum * 8; i++) bit_io(i[1], q);
    for (int i = 0; i < nrd * 8; i++) begin
      bit_io(~si, q);
      rdata = {rdata[6:0], q};
    end
    sck = idle;
    tick(HALF);
    select_low_pin = 1'b1;
    si = ~si;
    tick(8);
  endtask
endmodule

/* File: sim/sfc_top_tb_top.sv */
/*
  Self-checking bench for the serial flash front end.
  It assumes the host model owns the SPI pins and that both power-up delays are shortened.
*/
module sfc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam int PUW = 200;
  localparam int VCSL = 50;
  localparam int LIMIT = 40000;
  typedef struct {
    logic [7:0] op;
    int naddr;
    int ndum;
    logic known;
    logic rd;
  } sfc_row_t;
  sfc_row_t rows [12] = '{'{8'hd2, 24, 4, 1'b1, 1'b1}, '{8'hd1, 24, 0, 1'b1, 1'b1},
    '{8'hd3, 24, 0, 1'b1, 1'b1}, '{8'hd4, 24, 1, 1'b1, 1'b1}, '{8'hd6, 24, 1, 1'b1, 1'b1},
    '{8'h9f, 0, 0, 1'b1, 1'b1}, '{8'hb9, 0, 0, 1'b1, 1'b0}, '{8'hab, 0, 0, 1'b1, 1'b0},
    '{8'hb0, 0, 0, 1'b1, 1'b0}, '{8'hd0, 0, 0, 1'b1, 1'b0}, '{8'hd7, 0, 0, 1'b1, 1'b1},
    '{8'h55, 0, 0, 1'b0, 1'b0}};
  logic clk_sys = 1'b0;
  logic rst, por_active, sck, select_low_pin, si, so_dat, so_oe, rd_req, cmd_valid;
  logic mode3, active, standby, pe_allowed, read_allowed, oe_seen, act_at_cmd;
  logic [7:0] rd_byte, cmd_opcode, rdata;
  logic [sfc_pkg::PAGE_W-1:0] cmd_page;
  logic [sfc_pkg::BADDR_W-1:0] cmd_byte;
  logic [23:0] addr;
  int n_fail = 0;
  int compares = 0;
  int n_valid = 0;
  int n_req = 0;
  int cyc = 0;
  int nv0, cnt, nr0;

  always #2.5 clk_sys = ~clk_sys;

  sfc_top #(.PUW_CYCLES(PUW), .VCSL_CYCLES(VCSL)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .por_active(por_active), .sck(sck), .select_low_pin(select_low_pin), .si(si),
    .so_dat(so_dat), .so_oe(so_oe), .rd_byte(rd_byte), .rd_req(rd_req), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_page(cmd_page), .cmd_byte(cmd_byte), .mode3(mode3),
    .active(active), .standby(standby), .pe_allowed(pe_allowed),
    .read_allowed(read_allowed));

  sfc_host_model i_host (.clk_sys(clk_sys), .sck(sck), .select_low_pin(select_low_pin),
    .si(si), .so_dat(so_dat), .so_oe(so_oe));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Counting from the por release keeps both delay windows tied to one origin.
  task automatic wait_delays();
    cnt = 0;
    while (read_allowed !== 1'b1 && cnt < 1000) begin
      @(negedge clk_sys);
      cnt++;
    end
    chk("read_delay", cnt >= VCSL && cnt <= VCSL + 8, 1);
    while (pe_allowed !== 1'b1 && cnt < 1000) begin
      @(negedge clk_sys);
      cnt++;
    end
    chk("write_delay", cnt >= PUW && cnt <= PUW + 8, 1);
  endtask

  always @(negedge clk_sys) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      n_valid++;
      act_at_cmd = active;
    end
    if (rd_req === 1'b1)
      n_req++;
    if (so_oe === 1'b1)
      oe_seen = 1'b1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    por_active = 1'b1;
    rd_byte = 8'h00;
    oe_seen = 1'b0;
    act_at_cmd = 1'b0;
    @(negedge clk_sys);
    i_host.set_sel(1'b0);
    repeat (9) @(negedge clk_sys);
    chk("oe_in_reset", so_oe, 0);
    rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("ready_in_por", {read_allowed, pe_allowed, cmd_valid}, 0);
    por_active = 1'b0;
    wait_delays();
    repeat (3) @(negedge clk_sys);
    chk("active_sel_low", {active, standby}, 2'h2);
    nv0 = n_valid;
    i_host.frame(1'b0, 1'b0, 8'hd7, 24'h000000, 0, 0, 1, rdata);
    chk("no_fall_cmd", n_valid - nv0, 0);
    chk("no_fall_oe", oe_seen, 0);
    chk("standby_sel_high", {active, standby}, 2'h1);
    foreach (rows[i]) begin
      addr = 24'h5ab3c7 + 24'h011d05 * 24'(i);
      rd_byte = 8'h96 ^ rows[i].op;
      oe_seen = 1'b0;
      nv0 = n_valid;
      nr0 = n_req;
      i_host.frame(i[0], 1'b1, rows[i].op, addr, rows[i].naddr, rows[i].ndum, 1, rdata);
      chk("cmd_count", n_valid - nv0, rows[i].known);
      chk("oe_read", oe_seen, rows[i].rd);
      chk("rd_req_count", n_req - nr0, rows[i].rd ? 2 : 0);
      if (rows[i].rd)
        chk("read_data", rdata, rd_byte);
      if (rows[i].known) begin
        chk("opcode", cmd_opcode, rows[i].op);
        chk("page", cmd_page, rows[i].op == 8'hd2 ? addr[19:9] : 11'h000);
        chk("byte", cmd_byte, rows[i].naddr > 0 ? addr[8:0] : 9'h000);
        chk("mode", mode3, i[0]);
        chk("active_cmd", act_at_cmd, 1'b1);
      end
    end
    por_active = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("por_status", {pe_allowed, read_allowed, standby}, 0);
    oe_seen = 1'b0;
    nv0 = n_valid;
    i_host.frame(1'b1, 1'b1, 8'hd7, 24'h000000, 0, 0, 1, rdata);
    chk("por_cmd", n_valid - nv0, 0);
    chk("por_oe", oe_seen, 0);
    por_active = 1'b0;
    wait_delays();
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("rst_state", {so_oe, mode3, pe_allowed, active}, 0);
    rst = 1'b0;
    repeat (8) @(negedge clk_sys);
    rd_byte = 8'h3c;
    nv0 = n_valid;
    i_host.frame(1'b0, 1'b1, 8'hd7, 24'h000000, 0, 0, 1, rdata);
    chk("rst_cmd", n_valid - nv0, 1);
    chk("rst_data", rdata, 8'h3c);
    end_of_test();
  end
endmodule
